// *** shared/sdg_defs.svh ***
`ifndef SDG_DEFS_SVH
`define SDG_DEFS_SVH

// register byte addresses
`define SDG_ADDR_FLASH 6'h00
`define SDG_ADDR_THR1 6'h26
`define SDG_ADDR_THR2 6'h28
`define SDG_ADDR_SMPL1 6'h2A
`define SDG_ADDR_SMPL2 6'h2C
`define SDG_ADDR_ALMCTL 6'h2E
`define SDG_ADDR_PIN 6'h32
`define SDG_ADDR_MISC 6'h34
`define SDG_ADDR_ERR 6'h3C

// reset values and writable-bit masks
`define SDG_RST_WORD 16'h0000
`define SDG_MASK_PIN 16'h0303
`define SDG_MASK_MISC 16'h03C7
`define SDG_MASK_THR 16'hBFFF
`define SDG_MASK_SMPL 16'h00FF
`define SDG_MASK_ALMCTL 16'hFFD7

// field positions
`define SDG_BIT_ST_RUN 10
`define SDG_BIT_ST_NEG 9
`define SDG_BIT_ST_POS 8
`define SDG_BIT_BIAS 7
`define SDG_BIT_ALIGN 6
`define SDG_BIT_ERR_ST 5
`define SDG_BIT_IND_EN 2
`define SDG_BIT_IND_POL 1
`define SDG_BIT_IND_LINE 0
`define SDG_BIT_ALM_FILT 4
`define SDG_BIT_ROC1 6
`define SDG_BIT_LVL1 8

// counts and timing
`define SDG_NUM_SRC 11
`define SDG_SRC_MAX 4'hB
`define SDG_FLASH_CAP 16'h8000
`define SDG_CLK_MHZ 40
`define SDG_ST_TIME_US 35000
`define SDG_ST_CYCLES (`SDG_ST_TIME_US * `SDG_CLK_MHZ)

`endif

// *** shared/sdg_pkg.sv ***
package sdg_pkg;
    // one decoded register access from the serial port front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } sdg_req_t;

    // source words, index = source code minus one
    typedef logic [10:0][13:0] sdg_src_t;

    // self-test sequencer
    typedef enum logic [1:0] {
        SDG_ST_IDLE = 2'b01,
        SDG_ST_RUN = 2'b10
    } sdg_st_state_t;
endpackage

// *** src/sdg_alarm_eval.sv ***
`timescale 1ns/1ps
module sdg_alarm_eval (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // sample stream
    input wire logic i_update,
    input wire logic i_enable,
    input wire logic [13:0] i_sample,
    // configuration
    input wire logic i_roc,
    input wire logic [15:0] i_thr,
    input wire logic [7:0] i_nsamp,
    // one-cycle match pulse
    output logic o_hit
);
    logic [13:0] prev_reg;
    logic prev_ok_reg;
    logic [23:0] sum_reg;
    logic [23:0] sum_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic hit_reg;
    logic hit_next;

    // average compared as sum against threshold times count, so no divider is needed
    wire [7:0] n_eff = (i_nsamp == 8'h00) ? 8'h01 : i_nsamp;
    wire signed [14:0] delta = $signed({i_sample[13], i_sample}) - $signed({prev_reg[13], prev_reg});
    wire signed [23:0] sum_add = $signed(sum_reg) + 24'(delta);
    wire signed [22:0] thr_scaled = $signed(i_thr[13:0]) * $signed({1'b0, n_eff});
    wire signed [23:0] thr_ext = 24'(thr_scaled);
    wire gt_mode = i_thr[15];
    wire static_hit = gt_mode ? ($signed(i_sample) > $signed(i_thr[13:0]))
                              : ($signed(i_sample) < $signed(i_thr[13:0]));
    wire roc_hit = gt_mode ? (sum_add > thr_ext) : (sum_add < thr_ext);
    wire window_end = ((cnt_reg + 8'h01) == n_eff);

    // static compare per update, rate-of-change compare at the end of each window
    always_comb begin
        sum_next = sum_reg;
        cnt_next = cnt_reg;
        hit_next = 1'b0;
        if (i_enable && i_update && !i_roc) begin
            hit_next = static_hit;
        end
        if (!i_enable || !i_roc) begin
            sum_next = 24'h000000;
            cnt_next = 8'h00;
        end else if (i_update && prev_ok_reg) begin
            if (window_end) begin
                hit_next = roc_hit;
                sum_next = 24'h000000;
                cnt_next = 8'h00;
            end else begin
                sum_next = sum_add;
                cnt_next = cnt_reg + 8'h01;
            end
        end
    end

    // state update; the first sample after enable only seeds the previous value
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            prev_reg <= 14'h0000;
            prev_ok_reg <= 1'b0;
            sum_reg <= 24'h000000;
            cnt_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else begin
            sum_reg <= sum_next;
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
            if (!i_enable) begin
                prev_ok_reg <= 1'b0;
            end else if (i_update) begin
                prev_reg <= i_sample;
                prev_ok_reg <= 1'b1;
            end
        end
    end

    assign o_hit = hit_reg;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    AST_STATIC_HIT: assert property (i_enable && i_update && !i_roc |=> o_hit == $past(static_hit))
        else $error("static alarm compare result lost");
    AST_ROC_HIT: assert property (i_enable && i_roc && i_update && prev_ok_reg && window_end
        |=> o_hit == $past(roc_hit))
        else $error("rate alarm window result lost");
    AST_HIT_ON_UPDATE: assert property (!i_update |=> !o_hit)
        else $error("alarm hit outside an update");
endmodule

// *** src/sdg_diag_regs.sv ***
`timescale 1ns/1ps
`include "sdg_defs.svh"
// Functional notes
// - bits 0 and 1 of pin control set lines one and two as outputs.
// - level bits 8 and 9 drive outputs; reading gives input pin levels.
// - data-ready beats alarm, alarm beats general-purpose use of a line.
// - pin control is volatile and resets to zero, both lines inputs.
// - misc bit 2 enables data-ready, bit 1 polarity, bit 0 selects line.
// - writing misc bit 10 runs a 35 ms self-test, holding data, then clears.
// - error bit 5 gives self-test result, bits 10 to 15 the failing sensor.
// - misc bits 9 and 8 hold negative and positive manual stimulus levels.
// - misc bit 7 gyro bias compensation, bit 6 accelerometer alignment.
// - read-only flash write counter increments and wraps past 32,768.
// - overrange and supply flags clear by themselves once the cause ends.
// - reading error flags clears all; persisting causes reset at next update.
// - error bits 15 to 10 are per-sensor self-diagnostic failure flags.
// - error bits 9 and 8 alarm active, bit 3 link fail, bit 2 update fail.
// - error bit 1 supply above 5.25 V, bit 0 supply below 4.75 V.
// - two alarms, thresholds in source format with a compare direction bit.
// - rate-of-change mode averages sample deltas over the sample count.
// - alarm control selects source, mode, filtering and output line use.
// - threshold bit 15 picks greater-than; bits 13 to 0 hold the value.
// - alarm two source in 15:12, alarm one in 11:8, code zero disables.
// - alarm control bits 7 and 6 select rate-of-change for alarms two and one.
module sdg_diag_regs #(
    parameter int P_ST_CYCLES = `SDG_ST_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // register access
    input wire sdg_pkg::sdg_req_t i_req,
    output logic [15:0] o_rdata,
    // sample engine
    input wire logic i_update,
    input wire sdg_pkg::sdg_src_t i_src_raw,
    input wire sdg_pkg::sdg_src_t i_src_filt,
    input wire logic [5:0] i_st_fail,
    output logic o_data_hold,
    // condition inputs
    input wire logic i_overrange,
    input wire logic i_supply_high,
    input wire logic i_supply_low,
    input wire logic i_spi_fail,
    input wire logic i_ctrl_upd_fail,
    input wire logic i_flash_write,
    // sensor controls
    output logic o_gyro_st_pos,
    output logic o_gyro_st_neg,
    output logic o_accel_st_pos,
    output logic o_gyro_bias_comp,
    output logic o_accel_align,
    // digital lines
    input wire logic [1:0] i_dio_in,
    output logic [1:0] o_dio_out,
    output logic [1:0] o_dio_oe
);
    logic [15:0] pin_reg;
    logic [15:0] misc_reg;
    logic [15:0] alm_ctl_reg;
    logic [15:0] thr_reg [2];
    logic [15:0] smpl_reg [2];
    logic [15:0] err_reg;
    logic [15:0] err_next;
    logic [15:0] flash_reg;
    logic [15:0] rdata_reg;
    logic [5:0] st_diag_reg;
    logic [20:0] st_cnt_reg;
    sdg_pkg::sdg_st_state_t st_state_reg;
    sdg_pkg::sdg_st_state_t st_state_next;
    logic dr_pulse_reg;
    logic [1:0] dio_out_reg;
    logic [1:0] dio_oe_reg;
    logic [1:0] dio_out_next;
    logic [1:0] dio_oe_next;
    logic [1:0] alm_hit;
    logic [1:0] pin_rd;

    // address decode
    wire wr_pin = i_req.wr && (i_req.addr == `SDG_ADDR_PIN);
    wire wr_misc = i_req.wr && (i_req.addr == `SDG_ADDR_MISC);
    wire wr_almctl = i_req.wr && (i_req.addr == `SDG_ADDR_ALMCTL);
    wire rd_err = i_req.rd && (i_req.addr == `SDG_ADDR_ERR);

    // self-test sequencing; writes of bit 10 during a run are ignored
    wire st_running = (st_state_reg == sdg_pkg::SDG_ST_RUN);
    wire st_start = wr_misc && i_req.wdata[`SDG_BIT_ST_RUN] && !st_running;
    wire st_done = st_running && (st_cnt_reg == 21'(P_ST_CYCLES - 1));

    always_comb begin
        case (st_state_reg)
            sdg_pkg::SDG_ST_IDLE: begin
                st_state_next = st_start ? sdg_pkg::SDG_ST_RUN : sdg_pkg::SDG_ST_IDLE;
            end
            sdg_pkg::SDG_ST_RUN: begin
                st_state_next = st_done ? sdg_pkg::SDG_ST_IDLE : sdg_pkg::SDG_ST_RUN;
            end
            default: begin
                st_state_next = sdg_pkg::SDG_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_state_reg <= sdg_pkg::SDG_ST_IDLE;
            st_cnt_reg <= 21'h000000;
            st_diag_reg <= 6'h00;
        end else begin
            st_state_reg <= st_state_next;
            st_cnt_reg <= st_running ? st_cnt_reg + 21'h000001 : 21'h000000;
            if (st_done) begin
                st_diag_reg <= i_st_fail;
            end
        end
    end

    // control registers; only documented bits are kept
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_reg <= `SDG_RST_WORD;
            misc_reg <= `SDG_RST_WORD;
            alm_ctl_reg <= `SDG_RST_WORD;
        end else begin
            if (wr_pin) begin
                pin_reg <= i_req.wdata & `SDG_MASK_PIN;
            end
            if (wr_misc) begin
                misc_reg <= i_req.wdata & `SDG_MASK_MISC;
            end
            if (wr_almctl) begin
                alm_ctl_reg <= i_req.wdata & `SDG_MASK_ALMCTL;
            end
        end
    end

    // static sensor controls straight from misc control; data hold follows the self-test run
    assign o_gyro_st_pos = misc_reg[`SDG_BIT_ST_POS];
    assign o_gyro_st_neg = misc_reg[`SDG_BIT_ST_NEG];
    assign o_accel_st_pos = misc_reg[`SDG_BIT_ST_POS];
    assign o_gyro_bias_comp = misc_reg[`SDG_BIT_BIAS];
    assign o_accel_align = misc_reg[`SDG_BIT_ALIGN];
    assign o_data_hold = st_running;

    // per-alarm registers, source select and evaluator
    genvar ai;
    generate
        for (ai = 0; ai < 2; ai++) begin : g_alarm
            wire [5:0] thr_addr = (ai == 0) ? `SDG_ADDR_THR1 : `SDG_ADDR_THR2;
            wire [5:0] smpl_addr = (ai == 0) ? `SDG_ADDR_SMPL1 : `SDG_ADDR_SMPL2;
            wire [3:0] code = (ai == 0) ? alm_ctl_reg[11:8] : alm_ctl_reg[15:12];
            wire rate_of_change = alm_ctl_reg[`SDG_BIT_ROC1 + ai];
            wire en = (code != 4'h0) && (code <= `SDG_SRC_MAX);
            wire [3:0] sel = en ? code - 4'h1 : 4'h0;
            wire [13:0] sample = alm_ctl_reg[`SDG_BIT_ALM_FILT] ? i_src_filt[sel]
                                                                : i_src_raw[sel];
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    thr_reg[ai] <= `SDG_RST_WORD;
                    smpl_reg[ai] <= `SDG_RST_WORD;
                end else begin
                    if (i_req.wr && (i_req.addr == thr_addr)) begin
                        thr_reg[ai] <= i_req.wdata & `SDG_MASK_THR;
                    end
                    if (i_req.wr && (i_req.addr == smpl_addr)) begin
                        smpl_reg[ai] <= i_req.wdata & `SDG_MASK_SMPL;
                    end
                end
            end
            sdg_alarm_eval u_eval (
                .i_clk_sys(i_clk_sys),
                .i_rstn(i_rstn),
                .i_update(i_update),
                .i_enable(en),
                .i_sample(sample),
                .i_roc(rate_of_change),
                .i_thr(thr_reg[ai]),
                .i_nsamp(smpl_reg[ai][7:0]),
                .o_hit(alm_hit[ai])
            );
        end
    endgenerate

    // error flags: causes are applied after the read clear, so a set always wins
    always_comb begin
        err_next = rd_err ? 16'h0000 : err_reg;
        if (!i_overrange) begin
            err_next[4] = 1'b0;
        end
        if (!i_supply_high) begin
            err_next[1] = 1'b0;
        end
        if (!i_supply_low) begin
            err_next[0] = 1'b0;
        end
        if (i_update) begin
            err_next[4] = err_next[4] | i_overrange;
            err_next[1] = err_next[1] | i_supply_high;
            err_next[0] = err_next[0] | i_supply_low;
            err_next[15:10] = err_next[15:10] | st_diag_reg;
            err_next[`SDG_BIT_ERR_ST] = err_next[`SDG_BIT_ERR_ST] | (|st_diag_reg);
        end
        if (st_done) begin
            err_next[15:10] = err_next[15:10] | i_st_fail;
            err_next[`SDG_BIT_ERR_ST] = err_next[`SDG_BIT_ERR_ST] | (|i_st_fail);
        end
        err_next[9:8] = err_next[9:8] | alm_hit;
        err_next[3] = err_next[3] | i_spi_fail;
        err_next[2] = err_next[2] | i_ctrl_upd_fail;
    end

    // flash counter holds 0 to 32,768 and then wraps
    wire flash_at_cap = (flash_reg == `SDG_FLASH_CAP);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            err_reg <= `SDG_RST_WORD;
            flash_reg <= `SDG_RST_WORD;
        end else begin
            err_reg <= err_next;
            if (i_flash_write) begin
                flash_reg <= flash_at_cap ? 16'h0000 : flash_reg + 16'h0001;
            end
        end
    end

    // indicator levels; data-ready is withheld while the self-test runs
    wire ind_dr = misc_reg[`SDG_BIT_IND_EN];
    wire ind_al = alm_ctl_reg[`SDG_BIT_IND_EN];
    wire dr_level = misc_reg[`SDG_BIT_IND_POL] ? dr_pulse_reg : !dr_pulse_reg;
    wire al_active = |err_reg[9:8];
    wire al_level = alm_ctl_reg[`SDG_BIT_IND_POL] ? al_active : !al_active;

    // line ownership per line
    genvar li;
    generate
        for (li = 0; li < 2; li++) begin : g_line
            wire dr_claim = ind_dr && (misc_reg[`SDG_BIT_IND_LINE] == li);
            wire al_claim = ind_al && (alm_ctl_reg[`SDG_BIT_IND_LINE] == li);
            assign dio_oe_next[li] = dr_claim || al_claim || pin_reg[li];
            assign dio_out_next[li] = dr_claim ? dr_level
                                    : al_claim ? al_level
                                    : pin_reg[`SDG_BIT_LVL1 + li];
            assign pin_rd[li] = dio_oe_reg[li] ? dio_out_reg[li] : i_dio_in[li];
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            dr_pulse_reg <= 1'b0;
            dio_out_reg <= 2'h0;
            dio_oe_reg <= 2'h0;
        end else begin
            dr_pulse_reg <= i_update && !st_running;
            dio_out_reg <= dio_out_next;
            dio_oe_reg <= dio_oe_next;
        end
    end

    assign o_dio_out = dio_out_reg;
    assign o_dio_oe = dio_oe_reg;

    // read selection; unmapped addresses read zero
    wire [15:0] misc_rd = misc_reg | {5'h00, st_running, 10'h000};
    wire [15:0] pin_word = {6'h00, pin_rd, 6'h00, pin_reg[1:0]};
    wire [15:0] rd_mux =
        (i_req.addr == `SDG_ADDR_FLASH) ? flash_reg :
        (i_req.addr == `SDG_ADDR_THR1) ? thr_reg[0] :
        (i_req.addr == `SDG_ADDR_THR2) ? thr_reg[1] :
        (i_req.addr == `SDG_ADDR_SMPL1) ? smpl_reg[0] :
        (i_req.addr == `SDG_ADDR_SMPL2) ? smpl_reg[1] :
        (i_req.addr == `SDG_ADDR_ALMCTL) ? alm_ctl_reg :
        (i_req.addr == `SDG_ADDR_PIN) ? pin_word :
        (i_req.addr == `SDG_ADDR_MISC) ? misc_rd :
        (i_req.addr == `SDG_ADDR_ERR) ? err_reg : 16'h0000;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 16'h0000;
        end else if (i_req.rd) begin
            rdata_reg <= rd_mux;
        end
    end

    assign o_rdata = rdata_reg;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    AST_GPIO_DRIVE: assert property (!ind_dr && !ind_al && pin_reg[0]
        |=> o_dio_oe[0] && o_dio_out[0] == $past(pin_reg[8]))
        else $error("line one not driven from level bit");
    AST_GPIO_INPUT: assert property (!ind_dr && !ind_al && !pin_reg[1] |=> !o_dio_oe[1])
        else $error("line two driven while an input");
    AST_DR_FIRST: assert property (ind_dr && ind_al && !misc_reg[0] && !alm_ctl_reg[0]
        |=> o_dio_oe[0] && o_dio_out[0] == $past(dr_level))
        else $error("data-ready lost line priority");
    AST_PIN_RESET: assert property ($rose(i_rstn) |-> pin_reg == 16'h0000 && !o_dio_oe[0])
        else $error("pin control not cleared by reset");
    AST_ST_END: assert property (st_done |=> !misc_rd[10] && !o_data_hold)
        else $error("self-test bit not cleared at end");
    AST_ST_START: assert property (st_start |=> o_data_hold [*8])
        else $error("self-test did not hold data");
    AST_ST_RESULT: assert property (st_done && |i_st_fail |=> err_reg[5]
        && (err_reg[15:10] & $past(i_st_fail)) == $past(i_st_fail))
        else $error("self-test result not reported");
    AST_FLASH_WRAP: assert property (i_flash_write && flash_at_cap |=> flash_reg == 16'h0000)
        else $error("flash counter did not wrap");
    AST_AUTO_CLEAR: assert property (!i_supply_high |=> !err_reg[1])
        else $error("supply-high flag did not self-clear");
    AST_READ_CLEAR: assert property (rd_err && !i_update && !st_done && !i_spi_fail
        && !i_ctrl_upd_fail && alm_hit == 2'h0 |=> err_reg == 16'h0000)
        else $error("error flags not cleared by read");
    AST_LINK_FLAG: assert property (i_spi_fail |=> err_reg[3] [*1])
        else $error("link failure flag missed");
    AST_SUPPLY_LOW: assert property (i_update && i_supply_low |=> err_reg[0])
        else $error("supply-low flag missed");
    AST_ALARM_FLAG: assert property (alm_hit[1] |=> err_reg[9])
        else $error("alarm two flag missed");
    AST_OUT_READ: assert property (i_req.rd && i_req.addr == `SDG_ADDR_PIN && dio_oe_reg[0]
        |=> o_rdata[8] == $past(dio_out_reg[0]))
        else $error("output line read-back wrong");
endmodule

// *** verification/sdg_diag_regs_test.sv ***
`timescale 1ns/1ps
module sdg_diag_regs_test;
    logic i_clk_sys, i_rstn, upd, ovr, shi, slo, spif, cuf, fw, hold;
    logic gp, gn, ap, bc, al;
    logic [1:0] dio_in, dout, doe;
    logic [5:0] st_fail;
    logic [15:0] rdata, rv, w;
    sdg_pkg::sdg_req_t req;
    sdg_pkg::sdg_src_t src, srcf;
    int n_mismatch, checks, s, t, k, f;
    // every mapped word plus one unmapped place
    logic [5:0] adr [10] = '{6'h00, 6'h26, 6'h28, 6'h2A, 6'h2C,
        6'h2E, 6'h32, 6'h34, 6'h3C, 6'h3E};
    sdg_host_model sdg_host_model_inst (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_req(req));
    // short self-test keeps the run brief
    sdg_diag_regs #(.P_ST_CYCLES(20)) sdg_diag_regs_inst (.i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn), .i_req(req), .o_rdata(rdata), .i_update(upd), .i_src_raw(src),
        .i_src_filt(srcf), .i_st_fail(st_fail), .o_data_hold(hold), .i_overrange(ovr),
        .i_supply_high(shi), .i_supply_low(slo), .i_spi_fail(spif), .i_ctrl_upd_fail(cuf),
        .i_flash_write(fw), .o_gyro_st_pos(gp), .o_gyro_st_neg(gn), .o_accel_st_pos(ap),
        .o_gyro_bias_comp(bc), .o_accel_align(al), .i_dio_in(dio_in), .o_dio_out(dout),
        .o_dio_oe(doe));
    // clock
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one update pulse, then time for flags to land
    task automatic tick;
        @(posedge i_clk_sys) upd <= 1'b1;
        @(posedge i_clk_sys) upd <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask
    // outputs read back as driven, inputs as sampled
    function automatic logic [15:0] pin_exp(logic [15:0] v, logic [1:0] p);
        logic [1:0] lvl;
        lvl = (v[1:0] & v[9:8]) | (~v[1:0] & p);
        return {6'h00, lvl, 6'h00, v[1:0]};
    endfunction
    // watchdog: the flash wrap needs about 33,000 cycles, the rest a few hundred
    initial begin
        repeat (50000) @(posedge i_clk_sys);
        n_mismatch++;
        complete_run();
    end
    initial begin
        {upd, ovr, shi, slo, spif, cuf, fw, dio_in, st_fail} = '0;
        src = '0;
        srcf = '0;
        i_rstn = 1'b0;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(32'hB308));
        repeat (5) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        // reset values, unmapped place reads zero
        foreach (adr[i]) begin
            sdg_host_model_inst.rd(adr[i], rv);
            chk("reset value", 16'h0000, rv);
        end
        $display("reset test done");
        // digital lines, first the corner 0x0202
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 16'h0202 : 16'($urandom) & 16'h0303;
            @(posedge i_clk_sys) dio_in <= 2'($urandom);
            sdg_host_model_inst.wr(6'h32, w);
            sdg_host_model_inst.rd(6'h32, rv);
            chk("pin readback", pin_exp(w, dio_in), rv);
            chk("line enable", {14'h0000, w[1:0]}, {14'h0000, doe});
            chk("line level", {14'h0000, w[9:8] & w[1:0]}, {14'h0000, dout & w[1:0]});
        end
        $display("line test done");
        // stimulus and compensation enables
        for (int i = 0; i < 6; i++) begin
            w = 16'($urandom) & 16'h03C0;
            sdg_host_model_inst.wr(6'h34, w);
            sdg_host_model_inst.rd(6'h34, rv);
            chk("misc readback", w, rv);
            chk("stimulus", {11'h000, w[9:6], w[8]}, {11'h000, gn, gp, bc, al, ap});
        end
        // data-ready active low on line two must beat an active-high alarm indicator there
        sdg_host_model_inst.wr(6'h2E, 16'h0007);
        sdg_host_model_inst.wr(6'h34, 16'h0005);
        @(posedge i_clk_sys) upd <= 1'b1;
        @(posedge i_clk_sys) upd <= 1'b0;
        @(posedge i_clk_sys) #1 chk("ready pulse", 16'h0002, {14'h0000, doe[1], dout[1]});
        @(posedge i_clk_sys) #1 chk("ready idle", 16'h0003, {14'h0000, doe[1], dout[1]});
        sdg_host_model_inst.wr(6'h34, 16'h0000);
        $display("control test done");
        // error flags: set, read clear, reassert, self clear
        sdg_host_model_inst.rd(6'h3C, rv);
        @(posedge i_clk_sys) {shi, spif, cuf} <= 3'b111;
        @(posedge i_clk_sys) {spif, cuf} <= 2'b00;
        tick();
        sdg_host_model_inst.rd(6'h3C, rv);
        chk("flags set", 16'h000E, rv);
        sdg_host_model_inst.rd(6'h3C, rv);
        chk("flags cleared", 16'h0000, rv);
        tick();
        sdg_host_model_inst.rd(6'h3C, rv);
        chk("flag reasserted", 16'h0002, rv);
        tick();
        @(posedge i_clk_sys) {shi, slo, ovr} <= 3'b011;
        sdg_host_model_inst.rd(6'h3C, rv);
        chk("supply self clear", 16'h0000, rv);
        tick();
        sdg_host_model_inst.rd(6'h3C, rv);
        chk("low and overrange", 16'h0011, rv);
        @(posedge i_clk_sys) {slo, ovr} <= 2'b00;
        $display("flag test done");
        // self-test failing, then passing
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk_sys) st_fail <= (i == 0) ? 6'h2D : 6'h00;
            sdg_host_model_inst.rd(6'h3C, rv);
            sdg_host_model_inst.wr(6'h34, 16'h0400);
            @(posedge i_clk_sys) #1 chk("hold", 16'h0001, {15'h0000, hold});
            repeat (25) @(posedge i_clk_sys);
            #1 chk("hold end", 16'h0000, {15'h0000, hold});
            sdg_host_model_inst.rd(6'h34, rv);
            chk("run bit", 16'h0000, rv);
            sdg_host_model_inst.rd(6'h3C, rv);
            chk("test result", (i == 0) ? 16'hB420 : 16'h0000, rv);
        end
        $display("self-test done");
        // static alarms with random level and direction
        for (int i = 0; i < 8; i++) begin
            k = $urandom % 2;
            f = $urandom % 2;
            s = $urandom % 8000;
            t = $urandom % 8000;
            w = {1'($urandom), 1'b0, 14'(t)};
            sdg_host_model_inst.wr(6'h2E, ((k == 1) ? 16'h1000 : 16'h0100) | 16'(f << 4));
            sdg_host_model_inst.wr((k == 1) ? 6'h28 : 6'h26, w);
            sdg_host_model_inst.rd((k == 1) ? 6'h28 : 6'h26, rv);
            chk("threshold", w, rv);
            // the source not selected sits at the threshold, where it cannot trip
            @(posedge i_clk_sys) begin
                src[0] <= 14'(f ? t : s);
                srcf[0] <= 14'(f ? s : t);
            end
            sdg_host_model_inst.rd(6'h3C, rv);
            tick();
            sdg_host_model_inst.rd(6'h3C, rv);
            chk("alarm", {6'h00, (w[15] ? s > t : s < t) ? 2'(k + 1) : 2'b00, 8'h00}, rv);
        end
        sdg_host_model_inst.wr(6'h2E, 16'h0000);
        // rate of change: samples 0, 10, 20 give an average delta of 10 over two
        for (int j = 0; j < 2; j++) begin
            t = 5 + 7 * j;
            sdg_host_model_inst.wr(6'h2A, 16'h0002);
            sdg_host_model_inst.wr(6'h26, 16'h8000 | 16'(t));
            sdg_host_model_inst.wr(6'h2E, 16'h0140);
            sdg_host_model_inst.rd(6'h3C, rv);
            for (s = 0; s < 30; s += 10) begin
                @(posedge i_clk_sys) src[0] <= 14'(s);
                tick();
            end
            sdg_host_model_inst.rd(6'h3C, rv);
            chk("rate alarm", (10 > t) ? 16'h0100 : 16'h0000, rv);
            sdg_host_model_inst.wr(6'h2E, 16'h0000);
        end
        $display("alarm test done");
        // flash write counter
        repeat (3) begin
            @(posedge i_clk_sys) fw <= 1'b1;
            @(posedge i_clk_sys) fw <= 1'b0;
        end
        sdg_host_model_inst.rd(6'h00, rv);
        chk("flash count", 16'h0003, rv);
        // a held strobe counts every cycle; 32,768 more writes pass the top and wrap
        @(posedge i_clk_sys) fw <= 1'b1;
        repeat (32768) @(posedge i_clk_sys);
        fw <= 1'b0;
        sdg_host_model_inst.rd(6'h00, rv);
        chk("flash wrap", 16'((3 + 32768) % 32769), rv);
        $display("counter test done");
        complete_run();
    end
endmodule

// *** verification/sdg_host_model.sv ***
`timescale 1ns/1ps
module sdg_host_model (
    // clock
    input wire logic i_clk_sys,
    // register port toward the device
    input wire logic [15:0] i_rdata,
    output sdg_pkg::sdg_req_t o_req
);
    // port idles between accesses
    initial begin
        o_req = '0;
    end
    // one write, held only for the edge that takes it
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk_sys);
        o_req <= '0;
    endtask
    // no strobe marks read data, so it is taken a full cycle late
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        o_req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge i_clk_sys);
        o_req <= '0;
        @(posedge i_clk_sys);
        #1 d = i_rdata;
    endtask
endmodule
